// ==== ptc_defs.vh ====
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define PTC_IDX_TC0 8'h3D
`define PTC_IDX_NEIGH 8'h3E
`define PTC_ADDR_TC0 ({2'b00, `PTC_IDX_TC0, 2'b00})
`define PTC_ADDR_NEIGH ({2'b00, `PTC_IDX_NEIGH, 2'b00})

// ----------------------------------------------------------------------
// Field positions in test_control_0
// ----------------------------------------------------------------------
`define PTC_B_MAP_SEL 7
`define PTC_B_GLITCH 6
`define PTC_B_XFC 5
`define PTC_B_FORCE 4
`define PTC_B_VCO_MSB 3
`define PTC_B_UNIMP 2
`define PTC_B_BOOST 1
`define PTC_B_CRYSTAL_PIN 0

// ----------------------------------------------------------------------
// Field positions in test_control_1
// ----------------------------------------------------------------------
`define PTC_B1_PD_FORCE 7
`define PTC_B1_CLK_EN 6
`define PTC_B1_CLK_SEL_HI 5
`define PTC_B1_CLK_SEL_LO 4
`define PTC_B1_MON_DIS 3
`define PTC_B1_SQW_EN 2
`define PTC_B1_PD_UP 1
`define PTC_B1_PD_DOWN 0

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define PTC_RST_TC0 8'h00
`define PTC_RST_TC1 8'h00
`define PTC_RST_FMO 8'h00
`define PTC_TC0_IMPL 8'hFB
`define PTC_ALL_IMPL 8'hFF
`define PTC_TC0_KEEP 8'h40
`define PTC_NO_KEEP 8'h00

// ----------------------------------------------------------------------
// Bus codes and timing
// ----------------------------------------------------------------------
`define PTC_HSIZE_WORD 3'h2
`define PTC_FM_STEP_CYCLES 4'h4
`define PTC_FM_MULT_X1 3'h1
`define PTC_FM_MULT_X4 3'h4

`endif

// ==== ptc_fm_sweep.v ====
`timescale 1ns/1ns
`include "ptc_defs.vh"

module ptc_fm_sweep
(
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // Control
   input wire sweep_enable,
   // Sweep value
   output wire [7:0] sweep_code
);

   reg [7:0] code_reg;
   reg [7:0] code_next;
   reg down_reg;
   reg down_next;
   reg [3:0] div_reg;
   reg [3:0] div_next;

   always @*
   begin
      code_next = code_reg;
      down_next = down_reg;
      div_next = div_reg;
      if (!sweep_enable)
      begin
         code_next = 8'h00;
         down_next = 1'b0;
         div_next = 4'h0;
      end
      else if (div_reg != (`PTC_FM_STEP_CYCLES - 4'h1))
      begin
         div_next = div_reg + 4'h1;
      end
      else
      begin
         div_next = 4'h0;
         if (!down_reg)
         begin
            if (code_reg == 8'hFF)
            begin
               down_next = 1'b1;
               code_next = 8'hFE;
            end
            else
            begin
               code_next = code_reg + 8'h01;
            end
         end
         else
         begin
            if (code_reg == 8'h00)
            begin
               down_next = 1'b0;
               code_next = 8'h01;
            end
            else
            begin
               code_next = code_reg - 8'h01;
            end
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         code_reg <= 8'h00;
         down_reg <= 1'b0;
         div_reg <= 4'h0;
      end
      else
      begin
         code_reg <= code_next;
         down_reg <= down_next;
         div_reg <= div_next;
      end
   end

   assign sweep_code = code_reg;

endmodule // ptc_fm_sweep

// ==== ptc_reg8.v ====
`timescale 1ns/1ns

module ptc_reg8
#(
   parameter [7:0] RESET_VAL = 8'h00,
   parameter [7:0] IMPL_MASK = 8'hFF,
   parameter [7:0] KEEP_MASK = 8'h00
)
(
   // Clock and resets
   input wire ref_clk,
   input wire arst_n,
   input wire sync_clr,
   // Write port
   input wire wr_en,
   input wire [7:0] wr_data,
   // Stored value
   output wire [7:0] q
);

   reg [7:0] data_reg;
   reg [7:0] data_next;

   always @*
   begin
      data_next = data_reg;
      if (wr_en)
      begin
         data_next = wr_data & IMPL_MASK;
      end
      else if (sync_clr)
      begin
         data_next = (data_reg & KEEP_MASK) | (RESET_VAL & ~KEEP_MASK);
      end
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         data_reg <= RESET_VAL;
      end
      else
      begin
         data_reg <= data_next;
      end
   end

   assign q = data_reg;

endmodule // ptc_reg8

// ==== ptc_test_ctrl.v ====
`timescale 1ns/1ns
`include "ptc_defs.vh"

module ptc_test_ctrl
(
   // Clock and power-on reset
   input wire ref_clk,
   input wire arst_n,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // Chip mode and non power-on reset
   input wire special_mode,
   input wire sys_reset,
   // Inputs from neighbouring clock logic
   input wire freq_mod_enable,
   input wire ref_freq_range_1,
   input wire [1:0] vco_gain_low,
   input wire [1:0] fm_amplitude_select_in,
   // Frequency modulation controls
   output wire [7:0] fm_current_code,
   output wire [1:0] fm_amplitude_select,
   output wire [2:0] fm_amplitude_mult,
   // Loop filter and VCO controls
   output wire loop_filter_connect,
   output wire filter_node_force,
   output wire filter_force_third,
   output wire filter_force_half,
   output wire [2:0] vco_gain_sel,
   // Test and oscillator controls
   output wire glitch_filter_request,
   output wire crystal_digital_input_enable,
   output wire phase_detector_force,
   output wire pd_force_up,
   output wire pd_force_down,
   output wire test_clk_enable,
   output wire [1:0] test_clk_select,
   output wire osc_monitor_disable,
   output wire osc_ext_square_wave_enable
);

   // ----------------------------------------------------------------
   // Bus phase tracking
   // ----------------------------------------------------------------
   wire addr_phase;
   wire [7:0] tc0_q;
   wire [7:0] tc1_q;
   wire [7:0] fmo_q;
   wire [7:0] sweep_code;
   wire map_sel;
   wire wr_tc0;
   wire wr_tc1;
   wire wr_fmo;
   reg wr_pend_reg;
   reg wr_pend_next;
   reg [11:0] wr_addr_reg;
   reg [11:0] wr_addr_next;
   reg rd_pend_reg;
   reg rd_pend_next;
   reg [11:0] rd_addr_reg;
   reg [11:0] rd_addr_next;
   reg [31:0] hrdata_reg;
   reg [7:0] rd_byte;

   assign addr_phase = hsel & hready & htrans[1];
   assign map_sel = tc0_q[`PTC_B_MAP_SEL];

   always @*
   begin
      wr_pend_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      rd_pend_next = 1'b0;
      rd_addr_next = rd_addr_reg;
      if (addr_phase && hwrite && (hsize == `PTC_HSIZE_WORD))
      begin
         wr_pend_next = 1'b1;
         wr_addr_next = haddr[11:0];
      end
      else if (addr_phase && !hwrite)
      begin
         rd_pend_next = 1'b1;
         rd_addr_next = haddr[11:0];
      end
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= 12'h000;
      end
      else
      begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rd_pend_reg <= rd_pend_next;
         rd_addr_reg <= rd_addr_next;
      end
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // Special mode gate.
   assign wr_tc0 = wr_pend_reg & special_mode & (wr_addr_reg == `PTC_ADDR_TC0);
   assign wr_tc1 = wr_pend_reg & special_mode & ~map_sel &
      (wr_addr_reg == `PTC_ADDR_NEIGH);
   assign wr_fmo = wr_pend_reg & special_mode & map_sel &
      (wr_addr_reg == `PTC_ADDR_NEIGH);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   // Glitch bit survives system reset.
   ptc_reg8
   #(
      .RESET_VAL(`PTC_RST_TC0),
      .IMPL_MASK(`PTC_TC0_IMPL),
      .KEEP_MASK(`PTC_TC0_KEEP)
   )
   u_tc0
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sync_clr(sys_reset),
      .wr_en(wr_tc0),
      .wr_data(hwdata[7:0]),
      .q(tc0_q)
   );

   ptc_reg8
   #(
      .RESET_VAL(`PTC_RST_TC1),
      .IMPL_MASK(`PTC_ALL_IMPL),
      .KEEP_MASK(`PTC_NO_KEEP)
   )
   u_tc1
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sync_clr(sys_reset),
      .wr_en(wr_tc1),
      .wr_data(hwdata[7:0]),
      .q(tc1_q)
   );

   ptc_reg8
   #(
      .RESET_VAL(`PTC_RST_FMO),
      .IMPL_MASK(`PTC_ALL_IMPL),
      .KEEP_MASK(`PTC_NO_KEEP)
   )
   u_fmo
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sync_clr(sys_reset),
      .wr_en(wr_fmo),
      .wr_data(hwdata[7:0]),
      .q(fmo_q)
   );

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always @*
   begin
      rd_byte = 8'h00;
      if (rd_addr_reg == `PTC_ADDR_TC0)
      begin
         rd_byte = tc0_q & `PTC_TC0_IMPL;
      end
      else if ((rd_addr_reg == `PTC_ADDR_NEIGH) && map_sel)
      begin
         rd_byte = fmo_q;
      end
      else if (rd_addr_reg == `PTC_ADDR_NEIGH)
      begin
         rd_byte = tc1_q;
      end
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hrdata_reg <= 32'h0000_0000;
      end
      else if (rd_pend_reg)
      begin
         hrdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = ~rd_pend_reg;
   assign hresp = 1'b0;

   // ----------------------------------------------------------------
   // Frequency modulation code
   // ----------------------------------------------------------------
   reg [7:0] fm_code_reg;
   reg [7:0] fm_code_next;
   reg [2:0] fm_mult_reg;
   reg [1:0] fm_sel_reg;

   ptc_fm_sweep u_sweep
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sweep_enable(freq_mod_enable & ~map_sel),
      .sweep_code(sweep_code)
   );

   always @*
   begin
      fm_code_next = 8'h00;
      if (map_sel)
      begin
         fm_code_next = fmo_q;
      end
      else if (freq_mod_enable)
      begin
         fm_code_next = sweep_code;
      end
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fm_code_reg <= 8'h00;
         fm_mult_reg <= `PTC_FM_MULT_X1;
         fm_sel_reg <= 2'h0;
      end
      else
      begin
         fm_code_reg <= fm_code_next;
         fm_mult_reg <= tc0_q[`PTC_B_BOOST] ? `PTC_FM_MULT_X4 : `PTC_FM_MULT_X1;
         fm_sel_reg <= fm_amplitude_select_in;
      end
   end

   assign fm_current_code = fm_code_reg;
   assign fm_amplitude_mult = fm_mult_reg;
   assign fm_amplitude_select = fm_sel_reg;

   // ----------------------------------------------------------------
   // Loop filter, VCO and oscillator controls
   // ----------------------------------------------------------------
   reg third_reg;
   reg half_reg;
   reg [2:0] vco_sel_reg;

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         third_reg <= 1'b0;
         half_reg <= 1'b0;
         vco_sel_reg <= 3'h0;
      end
      else
      begin
         third_reg <= tc0_q[`PTC_B_FORCE] & ref_freq_range_1;
         half_reg <= tc0_q[`PTC_B_FORCE] & ~ref_freq_range_1;
         vco_sel_reg <= {tc0_q[`PTC_B_VCO_MSB], vco_gain_low};
      end
   end

   assign filter_force_third = third_reg;
   assign filter_force_half = half_reg;
   assign vco_gain_sel = vco_sel_reg;
   assign filter_node_force = tc0_q[`PTC_B_FORCE];
   assign loop_filter_connect = tc0_q[`PTC_B_XFC];
   assign glitch_filter_request = tc0_q[`PTC_B_GLITCH];
   assign crystal_digital_input_enable = tc0_q[`PTC_B_CRYSTAL_PIN];

   // ----------------------------------------------------------------
   // Test_control_1 fields
   // ----------------------------------------------------------------
   assign phase_detector_force = tc1_q[`PTC_B1_PD_FORCE];
   assign pd_force_up = tc1_q[`PTC_B1_PD_UP];
   assign pd_force_down = tc1_q[`PTC_B1_PD_DOWN];
   assign test_clk_enable = tc1_q[`PTC_B1_CLK_EN];
   assign test_clk_select = {tc1_q[`PTC_B1_CLK_SEL_HI], tc1_q[`PTC_B1_CLK_SEL_LO]};
   assign osc_monitor_disable = tc1_q[`PTC_B1_MON_DIS];
   assign osc_ext_square_wave_enable = tc1_q[`PTC_B1_SQW_EN];

endmodule // ptc_test_ctrl

// ==== ptc_test_ctrl_chk.sv ====
`timescale 1ns/1ns
`include "ptc_defs.vh"

module ptc_test_ctrl_chk
(
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // Controls
   input wire special_mode,
   input wire sys_reset,
   input wire ref_freq_range_1,
   input wire [2:0] vco_gain_sel,
   input wire [2:0] fm_amplitude_mult,
   input wire loop_filter_connect,
   input wire filter_node_force,
   input wire filter_force_third,
   input wire filter_force_half,
   input wire glitch_filter_request,
   input wire crystal_digital_input_enable
);
   // ------
   // Write tracking.
   // ------
   reg wr_tc0_reg;
   wire [3:0] tc0_bits;
   assign tc0_bits = {glitch_filter_request, loop_filter_connect, filter_node_force,
      crystal_digital_input_enable};
   always @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
         wr_tc0_reg <= 1'b0;
      else if (hready)
         wr_tc0_reg <= hsel && htrans[1] && hwrite && hsize == `PTC_HSIZE_WORD &&
            haddr[11:0] == `PTC_ADDR_TC0;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_wr_ok;
      wr_tc0_reg && special_mode ##1 !wr_tc0_reg && !sys_reset;
   endsequence

   a_resp_okay: assert property (!hresp && hrdata[31:8] == 24'h00_0000)
      else $error("bus response or upper read data wrong");
   a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> s_rd_wait)
      else $error("read data phase timing wrong");
   a_gfr_hold: assert property (!$past(wr_tc0_reg) |-> $stable(glitch_filter_request))
      else $error("glitch request changed without write");
   a_bits_hold: assert property (!$past(wr_tc0_reg) && !$past(sys_reset) |-> $stable(tc0_bits))
      else $error("control bits changed without write");
   a_wr_refused: assert property (wr_tc0_reg && !special_mode && !sys_reset |=> $stable(tc0_bits))
      else $error("write outside special mode took effect");
   a_wr_takes: assert property (wr_tc0_reg && special_mode |=>
      tc0_bits == {$past(hwdata[6:4]), $past(hwdata[0])})
      else $error("control bits do not follow write");
   a_boost_gain: assert property (s_wr_ok |=> vco_gain_sel[2] == $past(hwdata[3], 2) &&
      fm_amplitude_mult == ($past(hwdata[1], 2) ? 3'h4 : 3'h1))
      else $error("amplitude multiplier or gain msb wrong");
   a_force_third: assert property (filter_node_force && ref_freq_range_1 |=>
      filter_force_third && !filter_force_half)
      else $error("third supply force wrong");
   a_force_half: assert property (filter_node_force && !ref_freq_range_1 |=>
      filter_force_half && !filter_force_third)
      else $error("half supply force wrong");
endmodule // ptc_test_ctrl_chk

bind ptc_test_ctrl ptc_test_ctrl_chk ptc_test_ctrl_chk_i
(
   .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .special_mode(special_mode),
   .sys_reset(sys_reset), .ref_freq_range_1(ref_freq_range_1),
   .vco_gain_sel(vco_gain_sel), .fm_amplitude_mult(fm_amplitude_mult),
   .loop_filter_connect(loop_filter_connect), .filter_node_force(filter_node_force),
   .filter_force_third(filter_force_third), .filter_force_half(filter_force_half),
   .glitch_filter_request(glitch_filter_request),
   .crystal_digital_input_enable(crystal_digital_input_enable)
);

// ==== tb_pll_osc_test_control_reg.sv ====
`timescale 1ns/1ns
`include "ptc_defs.vh"

`define CHK(got, exp) \
   begin \
      total_checks = total_checks + 1; \
      if ((got) !== (exp)) \
      begin \
         n_errors = n_errors + 1; \
         $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module tb_pll_osc_test_control_reg;
   localparam [11:0] a_tc0 = `PTC_ADDR_TC0;
   localparam [11:0] a_nbr = `PTC_ADDR_NEIGH;
   reg ref_clk;
   reg arst_n;
   reg hsel;
   reg [31:0] haddr;
   reg [1:0] htrans;
   reg hwrite;
   reg [2:0] hsize;
   reg [31:0] hwdata;
   reg special_mode;
   reg sys_reset;
   reg freq_mod_enable;
   reg ref_freq_range_1;
   reg [1:0] vco_gain_low;
   reg [1:0] fsel_in;
   reg [31:0] rdata;
   reg [7:0] c0;
   integer n_errors;
   integer total_checks;
   wire [31:0] hrdata;
   wire hready;
   wire [7:0] fm_code;
   wire [1:0] fm_sel;
   wire [2:0] fm_mult;
   wire [2:0] vco_sel;
   wire lf_conn;
   wire fn_force;
   wire f_third;
   wire f_half;
   wire gfr;
   wire crystal_pin;
   wire [7:0] tc1_pins;
   wire [3:0] bits = {gfr, lf_conn, fn_force, crystal_pin};

   ptc_test_ctrl ptc_test_ctrl_i
   (
      .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(), .special_mode(special_mode), .sys_reset(sys_reset),
      .freq_mod_enable(freq_mod_enable), .ref_freq_range_1(ref_freq_range_1),
      .vco_gain_low(vco_gain_low), .fm_amplitude_select_in(fsel_in),
      .fm_current_code(fm_code), .fm_amplitude_select(fm_sel), .fm_amplitude_mult(fm_mult),
      .loop_filter_connect(lf_conn), .filter_node_force(fn_force),
      .filter_force_third(f_third), .filter_force_half(f_half), .vco_gain_sel(vco_sel),
      .glitch_filter_request(gfr), .crystal_digital_input_enable(crystal_pin),
      .phase_detector_force(tc1_pins[7]), .pd_force_up(tc1_pins[1]),
      .pd_force_down(tc1_pins[0]), .test_clk_enable(tc1_pins[6]),
      .test_clk_select(tc1_pins[5:4]), .osc_monitor_disable(tc1_pins[3]),
      .osc_ext_square_wave_enable(tc1_pins[2])
   );

   // ------
   // Bus tasks.
   // ------
   task cyc(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
      end
   endtask

   task bus(input [11:0] a, input w, input [2:0] sz, input [7:0] d);
      begin
         @(posedge ref_clk);
         hsel <= 1'b1;
         haddr <= {20'h0_0000, a};
         hwrite <= w;
         hsize <= sz;
         htrans <= 2'h2;
         @(posedge ref_clk);
         while (hready !== 1'b1) @(posedge ref_clk);
         htrans <= 2'h0;
         hwdata <= {24'h00_0000, d};
         @(posedge ref_clk);
         while (hready !== 1'b1) @(posedge ref_clk);
         rdata = hrdata;
      end
   endtask

   task wr(input [11:0] a, input [7:0] d);
      begin
         bus(a, 1'b1, `PTC_HSIZE_WORD, d);
      end
   endtask

   task rd(input [11:0] a);
      begin
         bus(a, 1'b0, `PTC_HSIZE_WORD, 8'h00);
      end
   endtask

   // ------
   // Scenarios.
   // ------
   task t_write;
      begin
         rd(a_tc0);
         `CHK(rdata, 32'h0000_0000)
         wr(a_nbr, 8'h80);
         cyc(1);
         `CHK(tc1_pins, 8'h80)
         wr(a_tc0, 8'hEB);
         cyc(1);
         `CHK(bits, 4'hD)
         cyc(1);
         `CHK(fm_mult, `PTC_FM_MULT_X4)
         `CHK(fm_sel, 2'h2)
         `CHK(vco_sel, 3'h7)
         `CHK({f_third, f_half}, 2'h0)
         wr(a_tc0, 8'hDF);
         cyc(2);
         `CHK(bits, 4'hB)
         `CHK({f_third, f_half}, 2'h2)
         ref_freq_range_1 <= 1'b0;
         cyc(2);
         `CHK({f_third, f_half}, 2'h1)
         rd(a_tc0);
         `CHK(rdata, 32'h0000_00DB)
      end
   endtask

   task t_refused;
      begin
         special_mode <= 1'b0;
         wr(a_tc0, 8'h00);
         special_mode <= 1'b1;
         bus(a_tc0, 1'b1, 3'h0, 8'h00);
         wr(12'h0FC, 8'hFF);
         rd(a_tc0);
         `CHK(rdata, 32'h0000_00DB)
         rd(12'h0FC);
         `CHK(rdata, 32'h0000_0000)
      end
   endtask

   task t_sysreset;
      begin
         sys_reset <= 1'b1;
         cyc(1);
         sys_reset <= 1'b0;
         rd(a_tc0);
         `CHK(rdata, 32'h0000_0040)
         `CHK(bits, 4'h8)
         `CHK(tc1_pins, 8'h00)
         arst_n <= 1'b0;
         cyc(3);
         arst_n <= 1'b1;
         cyc(1);
         `CHK(gfr, 1'b0)
         `CHK(fm_mult, `PTC_FM_MULT_X1)
      end
   endtask

   task t_map;
      begin
         wr(a_nbr, 8'h5A);
         wr(a_tc0, 8'h80);
         wr(a_nbr, 8'h3C);
         cyc(2);
         `CHK(fm_code, 8'h3C)
         freq_mod_enable <= 1'b1;
         cyc(8);
         `CHK(fm_code, 8'h3C)
         rd(a_nbr);
         `CHK(rdata, 32'h0000_003C)
         wr(a_tc0, 8'h00);
         rd(a_nbr);
         `CHK(rdata, 32'h0000_005A)
         `CHK(tc1_pins, 8'h5A)
         cyc(20);
         c0 = fm_code;
         cyc(8);
         `CHK(fm_code, c0 + 8'h02)
         cyc(1050);
         c0 = fm_code;
         cyc(8);
         `CHK(fm_code, c0 - 8'h02)
         freq_mod_enable <= 1'b0;
         cyc(3);
         `CHK(fm_code, 8'h00)
      end
   endtask

   task end_of_test;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial
   begin
      cyc(3000);
      n_errors = n_errors + 1;
      end_of_test;
   end

   initial
   begin
      n_errors = 0;
      total_checks = 0;
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      special_mode = 1'b1;
      sys_reset = 1'b0;
      freq_mod_enable = 1'b0;
      ref_freq_range_1 = 1'b1;
      vco_gain_low = 2'h3;
      fsel_in = 2'h2;
      cyc(3);
      arst_n <= 1'b1;
      t_write;
      t_refused;
      t_sysreset;
      t_map;
      end_of_test;
   end
endmodule // tb_pll_osc_test_control_reg
